//--- charger_pkg.sv
// shared constants, types and register map for the charger supervisor
package charger_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint unsigned CLK_HZ      = 64'h0000_0000_0BEB_C200;
  localparam longint unsigned MINUTE_S    = 64'h0000_0000_0000_003C;
  localparam longint unsigned MIN_CYCLES  = CLK_HZ * MINUTE_S;
  localparam int              MIN_W       = 34;
  localparam int              CNT_W       = 9;
  localparam int              DUTY_W      = 5;
  localparam logic [4:0]      DUTY_FULL   = 5'h10;

  // comparator thresholds, millivolts, for reference only
  localparam int              HOT_LIMIT_MV  = 32'h0000_01F4;
  localparam int              COLD_LIMIT_MV = 32'h0000_09CE;

  ////////////////////////////////////////////////////////////////////////////
  // time-out lengths in minutes
  localparam logic [8:0] PRE_40  = 9'h028;
  localparam logic [8:0] PRE_60  = 9'h03C;
  localparam logic [8:0] PRE_80  = 9'h050;
  localparam logic [8:0] TOT_3H  = 9'h0B4;
  localparam logic [8:0] TOT_4H  = 9'h0F0;
  localparam logic [8:0] TOT_5H  = 9'h12C;
  localparam logic [1:0] SEL_OFF = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [4:0] CTRL_ADDR   = 5'h00;
  localparam logic [4:0] STAT_ADDR   = 5'h04;
  localparam logic [4:0] IRQ_ST_ADDR = 5'h08;
  localparam logic [4:0] IRQ_CL_ADDR = 5'h0C;
  localparam logic [4:0] IRQ_EN_ADDR = 5'h10;
  localparam int         NUM_IRQ     = 5;
  localparam logic [9:0] CTRL_RESET  = 10'h000;

  typedef enum logic [2:0] {
    ST_PRECOND  = 3'b000,
    ST_FAST     = 3'b001,
    ST_TOPOFF   = 3'b010,
    ST_EOC      = 3'b011,
    ST_SUSPEND  = 3'b100,
    ST_TEMP_FLT = 3'b101,
    ST_TIME_FLT = 3'b110
  } charge_state_t;

  typedef struct packed {
    logic       timer_event_en;
    logic       total_irq_en;
    logic       precond_irq_en;
    logic       temp_event_en;
    logic       temp_return_irq_en;
    logic       temp_exit_irq_en;
    logic [1:0] total_timeout_sel;
    logic [1:0] precond_timeout_sel;
  } ctrl_t;

  typedef struct packed {
    logic supply_drop;
    logic total_exp;
    logic precond_exp;
    logic temp_return;
    logic temp_exit;
  } events_t;

  function automatic logic [8:0] precond_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    precond_limit = PRE_40;
      2'h1:    precond_limit = PRE_60;
      default: precond_limit = PRE_80;
    endcase
  endfunction

  function automatic logic [8:0] total_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    total_limit = TOT_3H;
      2'h1:    total_limit = TOT_4H;
      default: total_limit = TOT_5H;
    endcase
  endfunction

endpackage

//--- charger_properties.sv
// concurrent checks on the charger supervisor ports
module charger_properties (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic                       read,
  input wire logic                       waitrequest,
  input wire charger_pkg::charge_state_t charge_state,
  input wire logic                       new_cycle,
  input wire logic                       precond_timeout,
  input wire logic                       total_timeout,
  input wire logic                       temp_suspend,
  input wire logic                       ntc_hot_cmp,
  input wire logic                       ntc_cold_cmp,
  input wire logic                       supply_below_bat,
  input wire logic                       reverse_block,
  input wire logic                       charge_indicator_n_o,
  input wire logic                       charge_indicator_n_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic out_range = ntc_hot_cmp | ntc_cold_cmp;
  wire logic charging  = charge_state inside {charger_pkg::ST_PRECOND,
                                              charger_pkg::ST_FAST, charger_pkg::ST_TOPOFF};
  ////////////////////////////////////////////////////////////////////////////
  ind_drive_a: assert property (charge_indicator_n_oe == charging)
    else $error("indicator enable wrong");
  ind_sink_a: assert property (charge_indicator_n_oe |-> !charge_indicator_n_o)
    else $error("indicator not sinking");
  // two flops of sync on the async comparator
  rev_block_a: assert property ($rose(supply_below_bat) |-> ##2 reverse_block)
    else $error("reverse block late");
  temp_hold_a: assert property (out_range [*3] |-> temp_suspend)
    else $error("no suspend out of range");
  temp_clear_a: assert property (!out_range [*3] |-> !temp_suspend)
    else $error("suspend while in range");
  wait_one_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("wait state count wrong");
  pre_sticky_a: assert property (precond_timeout && !new_cycle |=> precond_timeout)
    else $error("precond expiry dropped");
  tot_sticky_a: assert property (total_timeout && !new_cycle |=> total_timeout)
    else $error("total expiry dropped");
  pre_state_a: assert property ($rose(precond_timeout) |->
    $past(charge_state) == charger_pkg::ST_PRECOND) else $error("precond ran off state");
  tot_state_a: assert property ($rose(total_timeout) |-> $past(charging))
    else $error("total ran off state");
  cover property ($rose(precond_timeout));
  cover property ($rose(temp_suspend));
  cover property ($rose(reverse_block));
endmodule // charger_properties

bind charger_supervisor charger_properties props (.sys_clk, .rst_n, .read, .waitrequest,
  .charge_state, .new_cycle, .precond_timeout, .total_timeout, .temp_suspend, .ntc_hot_cmp,
  .ntc_cold_cmp, .supply_below_bat, .reverse_block, .charge_indicator_n_o,
  .charge_indicator_n_oe);

//--- charger_supervisor.sv
// charger safety timers, status indicator and battery temperature events
// Notes on behaviour
// - precondition select: 40, 60, 80 min, off
// - total select: 3, 4, 5 hours, off
// - indicator pulled low only while actively charging
// - supply below battery blocks reverse current
// - suspend charging while temperature out of range
// - exit event interrupt needs both enables
// - return event interrupt needs both enables
// - live in-range status bit
// - temperature flag set on event, read clears
// - precondition expiry forces time-out fault
// - thermal current reduction stretches timers proportionally
// - timer flag set on expiry, read clears
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
module charger_supervisor #(
  parameter logic [33:0] MIN_CYCLES = 34'(charger_pkg::MIN_CYCLES)
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]                  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [3:0]                  byteenable,
  input  wire logic [31:0]                 writedata,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  // charge state machine, same clock
  input  wire charger_pkg::charge_state_t  charge_state,
  input  wire logic                        new_cycle,
  input  wire logic [4:0]                  charge_duty,
  output logic                             precond_timeout,
  output logic                             total_timeout,
  output logic                             temp_suspend,
  // analog comparators, asynchronous
  input  wire logic                        ntc_hot_cmp,
  input  wire logic                        ntc_cold_cmp,
  input  wire logic                        supply_below_bat,
  output logic                             reverse_block,
  // open-drain indicator
  input  wire logic                        charge_indicator_n_i,
  output logic                             charge_indicator_n_o,
  output logic                             charge_indicator_n_oe,
  output logic                             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [3:0] async_in;
  logic [3:0] meta_q;
  logic [3:0] sync_q;

  assign async_in = {charge_indicator_n_i, supply_below_bat, ntc_cold_cmp, ntc_hot_cmp};

  // comparators and the pin are asynchronous: two stages before any use
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic hot_s;
  logic cold_s;
  logic drop_s;
  logic pin_s;
  logic in_range;

  assign hot_s    = sync_q[0];
  assign cold_s   = sync_q[1];
  assign drop_s   = sync_q[2];
  assign pin_s    = sync_q[3];
  assign in_range = ~hot_s & ~cold_s;

  assign temp_suspend  = ~in_range;
  assign reverse_block = drop_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle per access
  logic        ack_q;
  logic        ack_d;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wmask;

  assign ack_d       = (read | write) & ~ack_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_en       = write & ack_q;
  // read data and clear-on-read share one edge, so no set slips between them
  assign rd_en       = read & ack_d;
  assign wmask       = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  logic wr_ctrl;
  logic wr_clear;
  logic wr_en_reg;
  logic rd_stat;

  // word select shared by every register decode
  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] word);
    addr_hit = (a == word);
  endfunction

  assign wr_ctrl   = wr_en & addr_hit(address, charger_pkg::CTRL_ADDR);
  assign wr_clear  = wr_en & addr_hit(address, charger_pkg::IRQ_CL_ADDR);
  assign wr_en_reg = wr_en & addr_hit(address, charger_pkg::IRQ_EN_ADDR);
  assign rd_stat   = rd_en & addr_hit(address, charger_pkg::STAT_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // control register
  charger_pkg::ctrl_t ctrl_q;
  charger_pkg::ctrl_t ctrl_d;
  logic [9:0]         wdata_m;

  assign wdata_m = (writedata[9:0] & wmask[9:0]) | (ctrl_q & ~wmask[9:0]);
  assign ctrl_d  = wr_ctrl ? charger_pkg::ctrl_t'(wdata_m) : ctrl_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= charger_pkg::ctrl_t'(charger_pkg::CTRL_RESET);
      ack_q  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ack_q  <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // minute prescaler, slowed by the duty of the charge current
  logic [4:0]  duty_eff;
  logic [5:0]  duty_sum;
  logic        duty_step;
  logic [4:0]  acc_q;
  logic [4:0]  acc_d;
  logic [33:0] pre_q;
  logic [33:0] pre_d;
  logic        minute_tick;

  // a share above full would let the accumulator run past full; clamp it
  assign duty_eff  = (charge_duty > charger_pkg::DUTY_FULL) ? charger_pkg::DUTY_FULL
                                                            : charge_duty;
  assign duty_sum  = {1'b0, acc_q} + {1'b0, duty_eff};
  assign duty_step = duty_sum >= {1'b0, charger_pkg::DUTY_FULL};
  assign acc_d     = duty_step ? 5'(duty_sum - {1'b0, charger_pkg::DUTY_FULL})
                               : duty_sum[4:0];
  assign minute_tick = duty_step & (pre_q == MIN_CYCLES - 34'h0_0000_0001);
  assign pre_d     = minute_tick ? '0 : (duty_step ? pre_q + 34'h0_0000_0001 : pre_q);

  // a reduced current advances time only by its share of full current
  always_ff @(posedge sys_clk) begin
    if (!rst_n || new_cycle) begin
      acc_q <= '0;
      pre_q <= '0;
    end else begin
      acc_q <= acc_d;
      pre_q <= pre_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state decode
  logic run_pre;
  logic run_tot;
  logic active;

  always_comb begin
    run_pre = 1'b0;
    run_tot = 1'b0;
    active  = 1'b0;
    case (charge_state)
      charger_pkg::ST_PRECOND: begin
        run_pre = 1'b1;
        run_tot = 1'b1;
        active  = 1'b1;
      end
      charger_pkg::ST_FAST,
      charger_pkg::ST_TOPOFF: begin
        run_tot = 1'b1;
        active  = 1'b1;
      end
      default: begin
        run_pre = 1'b0;
        run_tot = 1'b0;
        active  = 1'b0;
      end
    endcase
  end

  // open drain: only ever sinks, idle and fault states float to the pull-up
  assign charge_indicator_n_o  = 1'b0;
  assign charge_indicator_n_oe = active;

  ////////////////////////////////////////////////////////////////////////////
  // safety timers
  logic pre_exp;
  logic tot_exp;
  logic pre_pulse;
  logic tot_pulse;

  // both timers share one prescaler, so stretching applies to each alike
  safety_timer #(.CNT_W(charger_pkg::CNT_W)) u_pre_timer (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .run          (run_pre),
    .restart      (new_cycle),
    .minute_tick  (minute_tick),
    .disabled     (ctrl_q.precond_timeout_sel == charger_pkg::SEL_OFF),
    .limit        (charger_pkg::precond_limit(ctrl_q.precond_timeout_sel)),
    .expired      (pre_exp),
    .expire_pulse (pre_pulse)
  );

  safety_timer #(.CNT_W(charger_pkg::CNT_W)) u_tot_timer (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .run          (run_tot),
    .restart      (new_cycle),
    .minute_tick  (minute_tick),
    .disabled     (ctrl_q.total_timeout_sel == charger_pkg::SEL_OFF),
    .limit        (charger_pkg::total_limit(ctrl_q.total_timeout_sel)),
    .expired      (tot_exp),
    .expire_pulse (tot_pulse)
  );

  // expiry holds until the next cycle; the state machine moves to its fault
  assign precond_timeout = pre_exp;
  assign total_timeout   = tot_exp;

  ////////////////////////////////////////////////////////////////////////////
  // temperature edges and event flags
  logic range_q;
  logic exit_ev;
  logic return_ev;
  logic exit_hit;
  logic return_hit;
  logic pre_hit;
  logic tot_hit;
  logic temp_set;
  logic timer_set;
  logic temp_flag_q;
  logic timer_flag_q;

  // range_q reads the synced level, never the first stage
  assign exit_ev   = range_q & ~in_range;
  assign return_ev = ~range_q & in_range;
  assign exit_hit   = exit_ev & ctrl_q.temp_event_en & ctrl_q.temp_exit_irq_en;
  assign return_hit = return_ev & ctrl_q.temp_event_en & ctrl_q.temp_return_irq_en;
  assign temp_set   = exit_hit | return_hit;
  assign pre_hit    = pre_pulse & ctrl_q.timer_event_en & ctrl_q.precond_irq_en;
  assign tot_hit    = tot_pulse & ctrl_q.timer_event_en & ctrl_q.total_irq_en;
  assign timer_set  = pre_hit | tot_hit;

  // set beats a read clearing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      range_q      <= 1'b1; // matches in_range with the syncs at reset
      temp_flag_q  <= 1'b0;
      timer_flag_q <= 1'b0;
    end else begin
      range_q      <= in_range;
      temp_flag_q  <= temp_set | (temp_flag_q & ~rd_stat);
      timer_flag_q <= timer_set | (timer_flag_q & ~rd_stat);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status
  charger_pkg::events_t ev;
  logic [4:0]           irq_st_q;
  logic [4:0]           irq_en_q;
  logic [4:0]           irq_st_d;
  logic [4:0]           clr_bits;
  logic [4:0]           wbits;
  logic [4:0]           irq_en_d;
  logic                 reverse_q;

  assign ev.temp_exit   = exit_hit;
  assign ev.temp_return = return_hit;
  assign ev.precond_exp = pre_pulse;
  assign ev.total_exp   = tot_pulse;
  // only a new drop is an event; a supply that stays low raises it once
  assign ev.supply_drop = drop_s & ~reverse_q;

  assign wbits    = writedata[4:0] & wmask[4:0];
  assign clr_bits = wr_clear ? wbits : 5'h00;
  assign irq_st_d = ev | (irq_st_q & ~clr_bits);
  assign irq_en_d = wr_en_reg ? (wbits | (irq_en_q & ~wmask[4:0])) : irq_en_q;
  // level output: it falls only once software clears or masks the cause
  assign irq      = |(irq_st_q & irq_en_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_st_q  <= '0;
      irq_en_q  <= '0;
      reverse_q <= 1'b0;
    end else begin
      irq_st_q  <= irq_st_d;
      irq_en_q  <= irq_en_d;
      reverse_q <= drop_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address)
      charger_pkg::CTRL_ADDR:   rd_mux[9:0] = ctrl_q;
      charger_pkg::STAT_ADDR:   rd_mux[6:0] = {pin_s, drop_s, tot_exp, pre_exp,
                                               timer_flag_q, temp_flag_q,
                                               in_range};
      charger_pkg::IRQ_ST_ADDR: rd_mux[4:0] = irq_st_q;
      charger_pkg::IRQ_EN_ADDR: rd_mux[4:0] = irq_en_q;
      default:                  rd_mux      = 32'h0000_0000;
    endcase
  end

  // write-only and unmapped words read as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  assign readdata = rdata_q;

endmodule // charger_supervisor

//--- host_model.sv
// avalon-mm host model for the supervisor register port
module host_model (
  input  wire logic        sys_clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [4:0]  address,
  output logic             read,
  output logic             write,
  output logic      [3:0]  byteenable,
  output logic      [31:0] writedata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
  end
  // holds the request until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    byteenable <= be;
    writedata <= d;
    do @(posedge sys_clk); while (waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // released data must not look valid
    writedata <= ~d;
  endtask
endmodule // host_model

//--- safety_timer.sv
// minute counter with selectable limit and sticky expiry
module safety_timer #(
  parameter int CNT_W = 9
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic             minute_tick,
  input  wire logic             disabled,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expired,
  output logic                  expire_pulse
);

  logic [CNT_W-1:0] count_q;
  logic             expired_q;
  logic             hit;

  assign hit          = run & minute_tick & ~disabled & ~expired_q
                        & (count_q + 1'b1 >= limit);
  assign expired      = expired_q;
  assign expire_pulse = hit;

  // counting freezes outside running states, so a paused charge keeps its time
  always_ff @(posedge sys_clk) begin
    if (!rst_n || restart) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else if (run && minute_tick && !expired_q) begin
      count_q   <= count_q + 1'b1;
      expired_q <= hit;
    end
  end

endmodule // safety_timer

//--- testbench.sv
// self-checking bench for the charger supervisor
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, read, write, waitrequest, new_cycle, irq;
  logic precond_timeout, total_timeout, temp_suspend, reverse_block;
  logic ntc_hot_cmp, ntc_cold_cmp, supply_below_bat, ind_o, ind_oe;
  logic [4:0]  address, charge_duty;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata;
  charger_pkg::charge_state_t charge_state;
  int n_fail, checks_done;
  int cyc = 0;
  // pull-up on the open-drain pin
  wire logic ind_pin = ind_oe ? ind_o : 1'b1;

  host_model host (.sys_clk, .waitrequest, .readdata, .address, .read, .write,
                   .byteenable, .writedata);
  // ten cycles a minute keeps hour timers short
  charger_supervisor #(.MIN_CYCLES(34'h0_0000_000A)) dut (.sys_clk, .rst_n, .address,
    .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .charge_state,
    .new_cycle, .charge_duty, .precond_timeout, .total_timeout, .temp_suspend, .ntc_hot_cmp,
    .ntc_cold_cmp, .supply_below_bat, .reverse_block, .charge_indicator_n_i(ind_pin),
    .charge_indicator_n_o(ind_o), .charge_indicator_n_oe(ind_oe), .irq);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    host.xfer(1'b1, a, d, be, q);
  endtask
  task automatic settle();
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] s;
    rd(charger_pkg::CTRL_ADDR, s);
    chk("ctrl reset", s, 32'h0000_0000);
    wr(charger_pkg::CTRL_ADDR, 32'h0000_03FF, 4'hF);
    wr(charger_pkg::CTRL_ADDR, 32'h0000_0000, 4'h2);
    rd(charger_pkg::CTRL_ADDR, s);
    chk("ctrl lanes", s, 32'h0000_00FF);
    rd(5'h14, s);
    chk("unmapped", s, 32'h0000_0000);
    rd(charger_pkg::IRQ_CL_ADDR, s);
    chk("clear reg", s, 32'h0000_0000);
  endtask
  task automatic t_ind();
    for (int i = 0; i < 7; i++) begin
      charge_state <= charger_pkg::charge_state_t'(i);
      @(posedge sys_clk);
      chk("indicator oe", 32'(ind_oe), 32'(i < 3));
    end
  endtask
  task automatic t_supply();
    logic [31:0] s;
    supply_below_bat <= 1'b1;
    settle();
    chk("reverse block", 32'(reverse_block), 32'h0000_0001);
    rd(charger_pkg::IRQ_ST_ADDR, s);
    chk("drop event", s & 32'h0000_0010, 32'h0000_0010);
    wr(charger_pkg::IRQ_EN_ADDR, 32'h0000_0010, 4'hF);
    @(posedge sys_clk);
    chk("irq raised", 32'(irq), 32'h0000_0001);
    wr(charger_pkg::IRQ_EN_ADDR, 32'h0000_0000, 4'hF);
    @(posedge sys_clk);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(charger_pkg::IRQ_EN_ADDR, 32'h0000_0010, 4'hF);
    wr(charger_pkg::IRQ_CL_ADDR, 32'h0000_0010, 4'hF);
    @(posedge sys_clk);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    supply_below_bat <= 1'b0;
  endtask
  task automatic t_temp();
    logic [31:0] s;
    wr(charger_pkg::CTRL_ADDR, 32'h0000_0050, 4'hF);
    ntc_hot_cmp <= 1'b1;
    settle();
    chk("suspend", 32'(temp_suspend), 32'h0000_0001);
    rd(charger_pkg::STAT_ADDR, s);
    chk("exit flag", s & 32'h0000_0003, 32'h0000_0002);
    rd(charger_pkg::STAT_ADDR, s);
    chk("read clears", s & 32'h0000_0003, 32'h0000_0000);
    ntc_hot_cmp <= 1'b0;
    settle();
    rd(charger_pkg::STAT_ADDR, s);
    chk("return masked", s & 32'h0000_0003, 32'h0000_0001);
    wr(charger_pkg::CTRL_ADDR, 32'h0000_0060, 4'hF);
    ntc_cold_cmp <= 1'b1;
    settle();
    rd(charger_pkg::STAT_ADDR, s);
    chk("exit masked", s & 32'h0000_0003, 32'h0000_0000);
    ntc_cold_cmp <= 1'b0;
    settle();
    rd(charger_pkg::STAT_ADDR, s);
    chk("return flag", s & 32'h0000_0003, 32'h0000_0003);
    rd(charger_pkg::IRQ_ST_ADDR, s);
    chk("temp events", s & 32'h0000_0003, 32'h0000_0003);
    wr(charger_pkg::IRQ_CL_ADDR, 32'h0000_001F, 4'hF);
  endtask
  // lim is the expected run time in cycles; a 100 cycle pause must not count
  task automatic run_timer(input logic tot, input logic [1:0] sel, input logic [4:0] duty,
                           input int lim);
    logic [31:0] s;
    charger_pkg::charge_state_t st;
    st = tot ? charger_pkg::ST_FAST : charger_pkg::ST_PRECOND;
    wr(charger_pkg::CTRL_ADDR, 32'h0000_0380 | (tot ? {28'h0, sel, 2'h3} : {28'h0, 2'h3, sel}),
       4'hF);
    charge_duty <= duty;
    charge_state <= st;
    new_cycle <= 1'b1;
    @(posedge sys_clk);
    new_cycle <= 1'b0;
    repeat (lim / 2) @(posedge sys_clk);
    charge_state <= charger_pkg::ST_SUSPEND;
    repeat (100) @(posedge sys_clk);
    charge_state <= st;
    repeat (lim - lim / 2 - 15) @(posedge sys_clk);
    chk("early", 32'(tot ? total_timeout : precond_timeout), 32'h0);
    repeat (30) @(posedge sys_clk);
    chk("expiry", 32'(tot ? total_timeout : precond_timeout), 32'(sel != 2'h3));
    charge_state <= tot ? charger_pkg::ST_EOC : charger_pkg::ST_TIME_FLT;
    rd(charger_pkg::STAT_ADDR, s);
    chk("timer flag", 32'(s[2]), 32'(sel != 2'h3));
    rd(charger_pkg::STAT_ADDR, s);
    chk("flag cleared", 32'(s[2]), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    charge_state = charger_pkg::ST_EOC;
    new_cycle = 1'b0;
    charge_duty = 5'h10;
    ntc_hot_cmp = 1'b0;
    ntc_cold_cmp = 1'b0;
    supply_below_bat = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_ind();
    t_supply();
    t_temp();
    for (int i = 0; i < 4; i++) begin
      run_timer(1'b0, 2'(i), 5'h10, i == 3 ? 900 : 400 + 200 * i);
      run_timer(1'b1, 2'(i), 5'h10, i == 3 ? 3100 : 1800 + 600 * i);
    end
    // half current doubles the nominal period
    run_timer(1'b0, 2'h0, 5'h08, 800);
    close_out();
  end
endmodule // testbench
